// ===== rtl/dce_link_params.svh
`ifndef DCE_LINK_PARAMS_SVH
`define DCE_LINK_PARAMS_SVH

// core clock period
`define CLK_PERIOD_NS      4
// rounding of times into core clock cycles
`define NS_TO_CYC_UP(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NS_TO_CYC_DN(ns)   ((ns) / `CLK_PERIOD_NS)

// reset service: both lines low for two octet periods
`define RESET_HOLD_NS      2000
`define RESET_HOLD_CYC     `NS_TO_CYC_UP(`RESET_HOLD_NS)
`define RESET_CNT_W        10

// receive clock phase, each at least 0.04 of an octet period
`define RXC_PHASE_NS       60
`define RXC_PHASE_CYC      `NS_TO_CYC_UP(`RXC_PHASE_NS)
`define PHASE_CNT_W        5

// transmit framing lengths in line symbols
`define PREAMBLE_BASE      8
`define PREAMBLE_UNIT      8
`define SD_LEN             8
`define ED_LEN             8
`define GAP_BASE           16
`define GAP_UNIT           8
`define SYM_CNT_W          8

// payload limits in service octets
`define TX_OCTETS_MIN      3
`define TX_OCTETS_MAX      300
`define TX_BIT_CNT_W       12

// receive reporting limits
`define ED_REPORT_MAX      7
`define CHAN_BITS          3

`endif

// ===== rtl/dce_link_pkg.sv
package dce_link_pkg;

  typedef enum logic [2:0] {
    TX_IDLE, TX_PRE, TX_SD, TX_DATA, TX_ED, TX_GAP
  } tx_state_e;

  typedef enum logic [1:0] {
    RP_IDLE, RP_RUN, RP_DONE
  } rpt_state_e;

  typedef enum logic [1:0] {
    SYM_PREAMBLE, SYM_START_DELIM, SYM_DATA, SYM_END_DELIM
  } tx_kind_e;

  typedef enum logic [2:0] {
    RX_TRAIN, RX_CHAN, RX_SD_MATCH, RX_DATA, RX_ED_DATA, RX_ED_MATCH,
    RX_ERROR
  } rx_kind_e;

  // one line symbol toward the medium
  typedef struct packed {
    logic     valid;
    tx_kind_e kind;
    logic     data;
  } med_tx_s;

  // one decoded event from the receiver front end
  typedef struct packed {
    logic     valid;
    rx_kind_e kind;
    logic     data;
  } rx_item_s;

  // pins from the terminal side
  typedef struct packed {
    logic clk;
    logic req;
    logic txd;
  } dte_pins_s;

endpackage

// ===== rtl/dce_link_seq.sv
// Summary of operation
// (RULE1) transmission never overlaps reset; reset service aborts transmission at once
// (RULE2) terminal raises request between transmit clock rise and next fall
// (RULE3) on request, send preamble then start delimiter symbols to medium
// (RULE4) raise clear line before the falling edge that takes first payload bit
// (RULE5) terminal sends whole octets, 3 to 300, one bit per falling edge
// (RULE6) terminal ends payload by raising data and dropping request
// (RULE7) after payload send end delimiter symbols, then stop transmitting
// (RULE8) wait configured gap, then drop clear line after a falling edge
// (RULE9) fault drives activity and framing low until reset or configuration
// (RULE10) terminal tolerates both receive lines changing together at frame end
// (RULE11) activity high; framing fall starts report; activity fall ends it
// (RULE12) report only while activity is shown, never during fault
// (RULE13) start report: drive receive clock, lower framing in high phase
// (RULE14) delimiter reporting behaves as eight symbols with no extra delay
// (RULE15) optionally report channel number msb first over last three symbols
// (RULE16) on start delimiter match invert framing line in low phase
// (RULE17) report each decoded payload bit in order, one per clock cycle
// (RULE18) at most seven values reported from end delimiter symbols
// (RULE19) end delimiter match: framing high in high phase, low in low phase
// (RULE20) final phase raises framing; no new report until activity ends
// (RULE21) on error keep clock valid, force start delimiter phase to finish
// (RULE22) error after start delimiter: framing low then high, then finish
// (RULE23) transmit data taken on transmit clock falling edges, high is one
// (RULE24) terminal samples framing on receive clock falling edges
// (RULE25) reset service: request and data low for two octet periods
`timescale 1ns/100ps
`include "dce_link_params.svh"

module dce_link_seq (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // terminal side transmit pins
  input  wire logic                 transmit_clock_line,
  input  wire logic                 request_line,
  input  wire logic                 transmit_data_line,
  output logic                      clear_line,
  // terminal side receive pins
  output logic                      receive_clock_line,
  output logic                      receive_activity_line,
  output logic                      receive_data_framing_line,
  // configuration
  input  wire logic [2:0]           preamble_ext,
  input  wire logic [2:0]           gap_ext,
  input  wire logic                 config_start,
  input  wire logic                 chan_report_en,
  input  wire logic [2:0]           chan_id,
  // medium transmit side
  output dce_link_pkg::med_tx_s     med_tx,
  output logic                      med_tx_on,
  output logic                      tx_len_err,
  // medium receive side
  input  wire logic                 media_active,
  input  wire logic                 media_fault,
  input  dce_link_pkg::rx_item_s    rx_item,
  output logic                      rx_ready,
  // reset service detected
  output logic                      dte_reset
);

  localparam logic [`RESET_CNT_W-1:0] RESET_HOLD =
    `RESET_CNT_W'(`RESET_HOLD_CYC);
  localparam logic [`PHASE_CNT_W-1:0] PHASE_LAST =
    `PHASE_CNT_W'(`RXC_PHASE_CYC - 1);
  localparam logic [`TX_BIT_CNT_W-1:0] BITS_MIN =
    `TX_BIT_CNT_W'(`TX_OCTETS_MIN * 8);
  localparam logic [`TX_BIT_CNT_W-1:0] BITS_MAX =
    `TX_BIT_CNT_W'(`TX_OCTETS_MAX * 8);

  function automatic logic [`SYM_CNT_W-1:0] ext_len(
    input logic [2:0] ext, input int base, input int unit);
    ext_len = `SYM_CNT_W'(base + unit * int'(ext));
  endfunction

  // pin synchronisers
  dce_link_pkg::dte_pins_s          pin_meta_reg;
  dce_link_pkg::dte_pins_s          pin_sync_reg;
  logic                             txc_prev_reg;
  logic                             tx_fall;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_meta_reg <= '{clk: 1'b0, req: 1'b0, txd: 1'b1};
      pin_sync_reg <= '{clk: 1'b0, req: 1'b0, txd: 1'b1};
      txc_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= '{clk: transmit_clock_line, req: request_line,
                        txd: transmit_data_line};
      pin_sync_reg <= pin_meta_reg;
      txc_prev_reg <= pin_sync_reg.clk;
    end
  end

  assign tx_fall = txc_prev_reg && !pin_sync_reg.clk;

  // reset service detector
  logic [`RESET_CNT_W-1:0]          hold_cnt_reg;
  logic                             both_low;

  assign both_low = !pin_sync_reg.req && !pin_sync_reg.txd;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_cnt_reg <= '0;
      dte_reset    <= 1'b0;
    end else begin
      dte_reset <= both_low && (hold_cnt_reg == RESET_HOLD - 1'b1); // see (RULE25)
      if (!both_low)
        hold_cnt_reg <= '0;
      else if (hold_cnt_reg != RESET_HOLD)
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  // transmit sequencer
  dce_link_pkg::tx_state_e          tx_state_reg;
  logic [`SYM_CNT_W-1:0]            sym_cnt_reg;
  logic [`TX_BIT_CNT_W-1:0]         tx_bits_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_reg <= dce_link_pkg::TX_IDLE;
      sym_cnt_reg  <= '0;
      tx_bits_reg  <= '0;
      clear_line   <= 1'b0;
      med_tx_on    <= 1'b0;
      tx_len_err   <= 1'b0;
      med_tx       <= '0;
    end else if (dte_reset) begin
      tx_state_reg <= dce_link_pkg::TX_IDLE; // see (RULE1)
      clear_line   <= 1'b0;
      med_tx_on    <= 1'b0;
      med_tx       <= '0;
    end else begin
      med_tx.valid <= 1'b0;
      if (tx_fall) begin
        case (tx_state_reg)
          dce_link_pkg::TX_IDLE: begin
            if (pin_sync_reg.req) begin // see (RULE2)
              tx_state_reg <= dce_link_pkg::TX_PRE;
              sym_cnt_reg  <= ext_len(preamble_ext, `PREAMBLE_BASE,
                                      `PREAMBLE_UNIT);
              tx_bits_reg  <= '0;
              med_tx_on    <= 1'b1;
            end
          end
          dce_link_pkg::TX_PRE: begin
            med_tx <= '{valid: 1'b1, kind: dce_link_pkg::SYM_PREAMBLE,
                        data: 1'b0}; // see (RULE3)
            if (sym_cnt_reg == 8'h01) begin
              tx_state_reg <= dce_link_pkg::TX_SD;
              sym_cnt_reg  <= `SYM_CNT_W'(`SD_LEN);
            end else begin
              sym_cnt_reg <= sym_cnt_reg - 1'b1;
            end
          end
          dce_link_pkg::TX_SD: begin
            med_tx <= '{valid: 1'b1, kind: dce_link_pkg::SYM_START_DELIM,
                        data: 1'b0}; // see (RULE3)
            if (sym_cnt_reg == 8'h01) begin
              tx_state_reg <= dce_link_pkg::TX_DATA;
              clear_line   <= 1'b1; // see (RULE4)
            end else begin
              sym_cnt_reg <= sym_cnt_reg - 1'b1;
            end
          end
          dce_link_pkg::TX_DATA: begin
            if (pin_sync_reg.req) begin
              med_tx <= '{valid: 1'b1, kind: dce_link_pkg::SYM_DATA,
                          data: pin_sync_reg.txd}; // see (RULE23)
              if (tx_bits_reg != {`TX_BIT_CNT_W{1'b1}})
                tx_bits_reg <= tx_bits_reg + 1'b1;
            end else begin
              // request dropped ends the payload, whatever the data line holds
              tx_state_reg <= dce_link_pkg::TX_ED; // see (RULE6)
              sym_cnt_reg  <= `SYM_CNT_W'(`ED_LEN);
              tx_len_err   <= (tx_bits_reg[2:0] != 3'h0) ||
                              (tx_bits_reg < BITS_MIN) ||
                              (tx_bits_reg > BITS_MAX); // see (RULE5)
            end
          end
          dce_link_pkg::TX_ED: begin
            med_tx <= '{valid: 1'b1, kind: dce_link_pkg::SYM_END_DELIM,
                        data: 1'b0}; // see (RULE7)
            if (sym_cnt_reg == 8'h01) begin
              tx_state_reg <= dce_link_pkg::TX_GAP;
              sym_cnt_reg  <= ext_len(gap_ext, `GAP_BASE, `GAP_UNIT);
              med_tx_on    <= 1'b0;
            end else begin
              sym_cnt_reg <= sym_cnt_reg - 1'b1;
            end
          end
          dce_link_pkg::TX_GAP: begin
            if (sym_cnt_reg == 8'h01) begin
              tx_state_reg <= dce_link_pkg::TX_IDLE;
              clear_line   <= 1'b0; // see (RULE8)
            end else begin
              sym_cnt_reg <= sym_cnt_reg - 1'b1;
            end
          end
          default: tx_state_reg <= dce_link_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // fault notification, set wins over clear
  logic                             fault_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n)
      fault_reg <= 1'b0;
    else if (media_fault)
      fault_reg <= 1'b1; // see (RULE9)
    else if (dte_reset || config_start)
      fault_reg <= 1'b0;
  end

  // single entry holding register for receive events
  dce_link_pkg::rx_item_s           pend_reg;
  logic                             pop;
  logic                             pend_valid_n;

  assign pend_valid_n = pop ? 1'b0 :
                        (pend_reg.valid || (rx_item.valid && rx_ready));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_reg <= '0;
      rx_ready <= 1'b1;
    end else begin
      rx_ready <= !pend_valid_n;
      if (pop)
        pend_reg.valid <= 1'b0;
      else if (rx_item.valid && rx_ready)
        pend_reg <= rx_item;
    end
  end

  // reporting engine state
  dce_link_pkg::rpt_state_e         rp_state_reg;
  logic                             started_reg;
  logic                             sd_done_reg;
  logic                             final_due_reg;
  logic                             last_cyc_reg;
  logic [1:0]                       chan_idx_reg;
  logic [2:0]                       ed_cnt_reg;
  logic [2:0]                       bit_cnt_reg;
  logic                             in_cyc_reg;
  logic                             hi_half_reg;
  logic [`PHASE_CNT_W-1:0]          ph_cnt_reg;
  logic                             lo_val_reg;
  logic                             rxc_reg;
  logic                             rdf_reg;

  // decision for the next receive clock cycle
  logic                             go;
  logic                             hi_val;
  logic                             lo_val;
  logic                             start_set;
  logic                             sd_set;
  logic                             fin_set;
  logic                             done_set;
  logic                             chan_inc;
  logic                             ed_inc;
  logic                             bit_inc;
  logic                             is_err;

  always_comb begin
    go        = 1'b0;
    hi_val    = 1'b1;
    lo_val    = 1'b1;
    pop       = 1'b0;
    start_set = 1'b0;
    sd_set    = 1'b0;
    fin_set   = 1'b0;
    done_set  = 1'b0;
    chan_inc  = 1'b0;
    ed_inc    = 1'b0;
    bit_inc   = 1'b0;
    is_err    = (pend_reg.kind == dce_link_pkg::RX_ERROR) ||
                ((pend_reg.kind == dce_link_pkg::RX_ED_MATCH) &&
                 (!sd_done_reg || bit_cnt_reg != 3'h0)); // see (RULE21)
    if (rp_state_reg != dce_link_pkg::RP_RUN) begin
      pop = pend_reg.valid; // see (RULE12)
    end else if (!in_cyc_reg) begin
      if (final_due_reg) begin
        go       = 1'b1; // see (RULE20)
        done_set = 1'b1;
      end else if (pend_reg.valid) begin
        pop = 1'b1;
        if (is_err) begin
          if (!started_reg) begin
            go        = 1'b1; // see (RULE21)
            hi_val    = 1'b0;
            lo_val    = 1'b0;
            start_set = 1'b1;
            pop       = 1'b0;
          end else if (!sd_done_reg) begin
            go      = 1'b1; // see (RULE21)
            hi_val  = rdf_reg;
            lo_val  = !rdf_reg;
            sd_set  = 1'b1;
            fin_set = 1'b1;
          end else begin
            go      = 1'b1; // see (RULE22)
            hi_val  = 1'b0;
            lo_val  = 1'b1;
            fin_set = 1'b1;
          end
        end else begin
          case (pend_reg.kind)
            dce_link_pkg::RX_TRAIN: begin
              if (!started_reg) begin
                go        = 1'b1; // see (RULE13)
                hi_val    = 1'b0;
                lo_val    = 1'b0;
                start_set = 1'b1;
              end
            end
            dce_link_pkg::RX_CHAN: begin
              if (started_reg && !sd_done_reg && chan_report_en &&
                  chan_idx_reg != 2'(`CHAN_BITS)) begin
                go       = 1'b1; // see (RULE15)
                hi_val   = chan_id[2'd2 - chan_idx_reg];
                lo_val   = hi_val;
                chan_inc = 1'b1;
              end
            end
            dce_link_pkg::RX_SD_MATCH: begin
              if (started_reg && !sd_done_reg) begin
                go     = 1'b1; // see (RULE16)
                hi_val = rdf_reg;
                lo_val = !rdf_reg;
                sd_set = 1'b1;
              end
            end
            dce_link_pkg::RX_DATA: begin
              if (sd_done_reg) begin
                go      = 1'b1; // see (RULE17)
                hi_val  = pend_reg.data;
                lo_val  = pend_reg.data;
                bit_inc = 1'b1;
              end
            end
            dce_link_pkg::RX_ED_DATA: begin
              if (sd_done_reg && ed_cnt_reg != 3'(`ED_REPORT_MAX)) begin
                go     = 1'b1; // see (RULE18)
                hi_val = pend_reg.data;
                lo_val = pend_reg.data;
                ed_inc = 1'b1;
              end
            end
            dce_link_pkg::RX_ED_MATCH: begin
              go      = 1'b1; // see (RULE19)
              hi_val  = 1'b1;
              lo_val  = 1'b0;
              fin_set = 1'b1;
            end
            default: pop = 1'b1;
          endcase
        end
      end
    end
  end

  // receive clock cycle engine and phase flags
  always_ff @(posedge core_clk) begin
    if (!rst_n || fault_reg || !media_active) begin
      rp_state_reg  <= dce_link_pkg::RP_IDLE; // see (RULE11)
      started_reg   <= 1'b0;
      sd_done_reg   <= 1'b0;
      final_due_reg <= 1'b0;
      last_cyc_reg  <= 1'b0;
      chan_idx_reg  <= '0;
      ed_cnt_reg    <= '0;
      bit_cnt_reg   <= '0;
      in_cyc_reg    <= 1'b0;
      hi_half_reg   <= 1'b0;
      ph_cnt_reg    <= '0;
      lo_val_reg    <= 1'b1;
      rxc_reg       <= 1'b0;
      rdf_reg       <= 1'b1;
    end else begin
      case (rp_state_reg)
        dce_link_pkg::RP_IDLE: rp_state_reg <= dce_link_pkg::RP_RUN;
        dce_link_pkg::RP_RUN: begin
          if (go) begin
            in_cyc_reg  <= 1'b1;
            hi_half_reg <= 1'b1;
            ph_cnt_reg  <= PHASE_LAST;
            rxc_reg     <= 1'b1;
            rdf_reg     <= hi_val;
            lo_val_reg  <= lo_val;
            if (start_set)
              started_reg <= 1'b1;
            if (sd_set)
              sd_done_reg <= 1'b1;
            if (fin_set)
              final_due_reg <= 1'b1;
            if (done_set)
              last_cyc_reg <= 1'b1;
            if (chan_inc)
              chan_idx_reg <= chan_idx_reg + 1'b1;
            if (ed_inc)
              ed_cnt_reg <= ed_cnt_reg + 1'b1;
            if (bit_inc)
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (in_cyc_reg) begin
            if (ph_cnt_reg != '0) begin
              ph_cnt_reg <= ph_cnt_reg - 1'b1;
            end else if (hi_half_reg) begin
              hi_half_reg <= 1'b0;
              ph_cnt_reg  <= PHASE_LAST;
              rxc_reg     <= 1'b0;
              rdf_reg     <= lo_val_reg;
            end else begin
              in_cyc_reg <= 1'b0;
              if (last_cyc_reg)
                rp_state_reg <= dce_link_pkg::RP_DONE; // see (RULE20)
            end
          end
        end
        dce_link_pkg::RP_DONE: rp_state_reg <= dce_link_pkg::RP_DONE;
        default: rp_state_reg <= dce_link_pkg::RP_IDLE;
      endcase
    end
  end

  // receive pins, fault forces activity, framing and clock lines low together
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      receive_activity_line     <= 1'b0;
      receive_data_framing_line <= 1'b1;
      receive_clock_line        <= 1'b0;
    end else begin
      receive_activity_line     <= !fault_reg && media_active; // see (RULE9)
      receive_data_framing_line <= !fault_reg && rdf_reg; // see (RULE12)
      receive_clock_line        <= !fault_reg && rxc_reg;
    end
  end

endmodule

// ===== test/link_checker.sv
`timescale 1ns/100ps
module link_checker (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  // watched ports
  input wire logic                  clear_line,
  input wire logic                  receive_clock_line,
  input wire logic                  receive_activity_line,
  input wire logic                  receive_data_framing_line,
  input wire logic                  config_start,
  input wire dce_link_pkg::med_tx_s med_tx,
  input wire logic                  med_tx_on,
  input wire logic                  media_active,
  input wire logic                  media_fault,
  input wire logic                  dte_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] hi_cnt_reg;
  logic       both_low;
  assign both_low = !receive_activity_line && !receive_data_framing_line;
  // length of the current high phase of the receive clock
  always_ff @(posedge core_clk) begin
    if (!rst_n || !receive_clock_line)
      hi_cnt_reg <= 8'h00;
    else
      hi_cnt_reg <= hi_cnt_reg + 8'h01;
  end
  fault_set_a: assert property (media_fault |-> ##[1:3] both_low)
    else $error("fault not shown on receive lines");
  fault_hold_a: assert property (both_low && !config_start && !dte_reset
    && !$past(config_start) && !$past(dte_reset) |=> both_low)
    else $error("fault indication released early");
  clear_data_a: assert property (med_tx.valid
    && med_tx.kind == dce_link_pkg::SYM_DATA |-> clear_line)
    else $error("payload symbol without clear line");
  pre_clear_a: assert property (med_tx.valid
    && med_tx.kind == dce_link_pkg::SYM_PREAMBLE |-> !clear_line)
    else $error("clear line high during preamble");
  reset_abort_a: assert property (dte_reset |=> !med_tx_on && !clear_line)
    else $error("reset service did not stop transmission");
  rxclk_high_a: assert property ($fell(receive_clock_line)
    |-> hi_cnt_reg == 8'h0F)
    else $error("receive clock high phase length wrong");
  framing_sync_a: assert property (receive_activity_line
    && $past(receive_activity_line) && $changed(receive_data_framing_line)
    |-> $changed(receive_clock_line))
    else $error("framing changed off a receive clock edge");
  activity_src_a: assert property (receive_activity_line
    |-> $past(media_active))
    else $error("activity shown without media activity");
  cover property (med_tx.valid && med_tx.kind == dce_link_pkg::SYM_END_DELIM);
  cover property ($fell(receive_clock_line));
  cover property (dte_reset);
  cover property (both_low);
endmodule
bind dce_link_seq link_checker link_checker_i (.*);

// ===== test/dte_model.sv
`timescale 1ns/100ps
module dte_model (
  // core clock for receive sampling
  input  wire logic core_clk,
  // transmit pins
  output logic      transmit_clock_line,
  output logic      request_line,
  output logic      transmit_data_line,
  input  wire logic clear_line,
  input  wire logic med_tx_on,
  // receive pins
  input  wire logic receive_clock_line,
  input  wire logic receive_activity_line,
  input  wire logic receive_data_framing_line
);
  logic q_hi[$];
  logic q_lo[$];
  logic rc_reg;
  logic rd_reg;
  initial begin
    transmit_clock_line = 1'b0;
    request_line = 1'b0;
    transmit_data_line = 1'b1;
  end
  // one transmit clock cycle; data settles before request moves
  task automatic tick(input logic r, input logic d);
    transmit_clock_line = 1'b1;
    #10;
    transmit_data_line = d;
    #5;
    request_line = r;
    #47.5;
    transmit_clock_line = 1'b0;
    #62.5;
  endtask
  task automatic frame(input int nbits, input logic [7:0] pat,
                       output int gap);
    int n;
    gap = 0;
    n = 0;
    tick(1'b1, 1'b1);
    while (!clear_line && n < 100) begin
      tick(1'b1, 1'b1);
      n++;
    end
    for (int i = 0; i < nbits; i++)
      tick(1'b1, pat[7 - i % 8]);
    n = 0;
    while (clear_line && n < 200) begin
      if (!med_tx_on)
        gap++;
      tick(1'b0, 1'b1);
      n++;
    end
  endtask
  task automatic reset_service();
    transmit_data_line = 1'b0;
    #2100;
    transmit_data_line = 1'b1;
  endtask
  // framing read only at receive clock edges, never on activity changes
  always @(posedge core_clk) begin
    rc_reg <= receive_clock_line;
    rd_reg <= receive_data_framing_line;
    if (rc_reg && !receive_clock_line)
      q_hi.push_back(rd_reg);
    if (!rc_reg && receive_clock_line && receive_activity_line)
      q_lo.push_back(rd_reg);
  end
endmodule

// ===== test/phy_dte_dce_frame_signalling_bench.sv
`timescale 1ns/100ps
`include "dce_link_params.svh"
module phy_dte_dce_frame_signalling_bench;
  logic core_clk;
  logic rst_n;
  logic transmit_clock_line;
  logic request_line;
  logic transmit_data_line;
  logic clear_line;
  logic receive_clock_line;
  logic receive_activity_line;
  logic receive_data_framing_line;
  logic config_start;
  logic media_active;
  logic media_fault;
  logic med_tx_on;
  logic tx_len_err;
  logic rx_ready;
  logic dte_reset;
  logic [2:0] preamble_ext;
  logic [2:0] gap_ext;
  logic [2:0] chan_id;
  logic chan_report_en;
  dce_link_pkg::med_tx_s  med_tx;
  dce_link_pkg::rx_item_s rx_item;
  int   mismatches;
  int   n_tests;
  int   cycles;
  int   n_rst;
  int   n_kind[4];
  logic tx_bits[$];
  logic exp_hi[$];
  logic exp_lo[$];

  dce_link_seq dce_link_seq_i (.*);
  dte_model dte_model_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (med_tx.valid)
      n_kind[med_tx.kind] <= n_kind[med_tx.kind] + 1;
    if (med_tx.valid && med_tx.kind == dce_link_pkg::SYM_DATA)
      tx_bits.push_back(med_tx.data);
    if (dte_reset)
      n_rst <= n_rst + 1;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // item held until taken; expected framing in high and low phase
  task automatic rp(input dce_link_pkg::rx_kind_e k, input logic d,
                    input logic h, input logic l);
    rx_item = '{1'b1, k, d};
    while (!rx_ready) cyc(1);
    cyc(1);
    exp_hi.push_back(h);
    exp_lo.push_back(l);
  endtask
  task automatic cmp_rx();
    rx_item = '0;
    cyc(120);
    exp_lo.push_front(1'b1);
    void'(exp_lo.pop_back());
    chk(dte_model_i.q_hi.size(), exp_hi.size());
    chk(dte_model_i.q_lo.size(), exp_lo.size());
    foreach (exp_hi[i]) chk(dte_model_i.q_hi[i], exp_hi[i]);
    foreach (exp_lo[i]) chk(dte_model_i.q_lo[i], exp_lo[i]);
    dte_model_i.q_hi.delete();
    dte_model_i.q_lo.delete();
    exp_hi.delete();
    exp_lo.delete();
  endtask

  task automatic t_tx(input int nbits, input logic err);
    int gap;
    n_kind = '{default: 0};
    tx_bits.delete();
    dte_model_i.frame(nbits, 8'hC5, gap);
    cyc(4);
    chk(n_kind[0], `PREAMBLE_BASE + `PREAMBLE_UNIT);
    chk(n_kind[1], `SD_LEN);
    chk(n_kind[2], nbits);
    chk(n_kind[3], `ED_LEN);
    chk(gap, `GAP_BASE + `GAP_UNIT);
    chk(tx_len_err, err);
    foreach (tx_bits[i]) chk(tx_bits[i], 8'hC5 >> (7 - i % 8) & 1);
  endtask
  task automatic t_rx_ok();
    media_active = 1'b1;
    cyc(3);
    rp(dce_link_pkg::RX_TRAIN, 1'b0, 1'b0, 1'b0);
    rp(dce_link_pkg::RX_CHAN, 1'b1, 1'b1, 1'b1);
    rp(dce_link_pkg::RX_CHAN, 1'b0, 1'b0, 1'b0);
    rp(dce_link_pkg::RX_CHAN, 1'b1, 1'b1, 1'b1);
    rp(dce_link_pkg::RX_SD_MATCH, 1'b0, 1'b1, 1'b0);
    for (int i = 7; i >= 0; i--)
      rp(dce_link_pkg::RX_DATA, 8'hA5 >> i & 1, 8'hA5 >> i & 1,
         8'hA5 >> i & 1);
    rp(dce_link_pkg::RX_ED_DATA, 1'b1, 1'b1, 1'b1);
    rp(dce_link_pkg::RX_ED_DATA, 1'b0, 1'b0, 1'b0);
    rp(dce_link_pkg::RX_ED_MATCH, 1'b0, 1'b1, 1'b0);
    exp_hi.push_back(1'b1);
    exp_lo.push_back(1'b1);
    cyc(120);
    rx_item = '{1'b1, dce_link_pkg::RX_TRAIN, 1'b0};
    cyc(2);
    cmp_rx();
    media_active = 1'b0;
    cyc(3);
  endtask
  task automatic t_rx_err();
    media_active = 1'b1;
    cyc(3);
    rp(dce_link_pkg::RX_TRAIN, 1'b0, 1'b0, 1'b0);
    rp(dce_link_pkg::RX_SD_MATCH, 1'b0, 1'b0, 1'b1);
    rp(dce_link_pkg::RX_DATA, 1'b1, 1'b1, 1'b1);
    rp(dce_link_pkg::RX_DATA, 1'b0, 1'b0, 1'b0);
    rp(dce_link_pkg::RX_ERROR, 1'b0, 1'b0, 1'b1);
    exp_hi.push_back(1'b1);
    exp_lo.push_back(1'b1);
    cmp_rx();
    media_active = 1'b0;
    cyc(3);
  endtask
  task automatic t_fault();
    media_active = 1'b1;
    cyc(3);
    media_fault = 1'b1;
    cyc(1);
    media_fault = 1'b0;
    rx_item = '{1'b1, dce_link_pkg::RX_TRAIN, 1'b0};
    cyc(40);
    rx_item = '0;
    chk({receive_activity_line, receive_data_framing_line}, 0);
    chk(dte_model_i.q_hi.size(), 0);
    config_start = 1'b1;
    cyc(1);
    config_start = 1'b0;
    cyc(4);
    chk({receive_activity_line, receive_data_framing_line}, 3);
    media_fault = 1'b1;
    cyc(1);
    media_fault = 1'b0;
    dte_model_i.reset_service();
    cyc(4);
    chk(n_rst, 1);
    chk({receive_activity_line, receive_data_framing_line}, 3);
    media_active = 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    config_start = 1'b0;
    media_active = 1'b0;
    media_fault = 1'b0;
    rx_item = '0;
    preamble_ext = 3'h1;
    gap_ext = 3'h1;
    chan_report_en = 1'b1;
    chan_id = 3'h5;
    cyc(4);
    rst_n = 1'b1;
    cyc(4);
    t_tx(24, 1'b0);
    t_tx(25, 1'b1);
    t_rx_ok();
    t_rx_err();
    t_fault();
    results();
  end
endmodule
